// *** logic/spd_pkg.sv ***
/*
  constants, register layout and carrier types for the divider c post-divider
  with frame pulse mode. assumes a single 100 MHz clock (mclk) standing in for
  the synthesizer vco clock, and a plain register port.
*/
// Notes on behaviour
// [R1] mode nibble 1111 selects frame pulse output
// [R2] otherwise divide by 24-bit ratio, 50% duty; odd ratios run high one mclk cycle longer than low
// [R3] software keeps normal ratio at most 0xefffff
// [R4] pulse spacing is bits 15:0 related periods
// [R5] bits 17:16 pick related clock a/b/d
// [R6] software never selects itself or reserved code
// [R7] bit 18 inverts pulse polarity
// [R8] bit 19 picks mid or edge boundary; the frame pulse logic never reads bit 19
// [R9] pulse edges align to related clock edges
package spd_pkg;
  localparam logic [7:0] cfg_off_lo = 8'h9e;
  localparam logic [7:0] cfg_off_mid = 8'h9f;
  localparam logic [7:0] cfg_off_hi = 8'ha0;
  localparam logic [23:0] cfg_reset = 24'h000000;
  localparam logic [3:0] frame_mode_code = 4'hf;
  localparam logic [23:0] ratio_max = 24'hefffff;
  localparam logic [1:0] sel_a = 2'h0;
  localparam logic [1:0] sel_b = 2'h1;
  localparam logic [1:0] sel_rsvd = 2'h2;
  localparam logic [1:0] sel_d = 2'h3;
  localparam int mode_msb = 23;
  localparam int mode_lsb = 20;
  localparam int type_bit = 19;
  localparam int polar_bit = 18;
  localparam int sel_msb = 17;
  localparam int sel_lsb = 16;
  localparam int period_msb = 15;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spd_bus_type;

  typedef enum logic [1:0] {
    spd_st_div = 2'b00,
    spd_st_wait = 2'b01,
    spd_st_pulse = 2'b11
  } spd_state_type;
endpackage

// *** logic/spd_rel_edge.sv ***
/*
  edge finder for the three related post-divider clocks; they arrive from
  sibling dividers so each passes three flops and counts when stages 2 and 3 agree.
*/
`timescale 1ns/1ps
module spd_rel_edge (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] rel_clk,
  input wire logic [1:0] sel,
  output logic rise
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
  } spd_sync_type;
  spd_sync_type st_r, st_nxt;
  logic [1:0] idx;

  // map select code onto rel_clk index: a=0, b=1, d=2
  always_comb
  begin
    idx = (sel == spd_pkg::sel_d) ? 2'h2 : sel;
    st_nxt = st_r;
    st_nxt.s1 = rel_clk;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.lvl = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.lvl & (st_r.s2 ^ st_r.s3));
    rise = st_nxt.lvl[idx] & ~st_r.lvl[idx];
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

// *** logic/spd_top.sv ***
/*
  divider c post-divider: 24-bit config register, divider (50% on even ratios), frame pulse mode.
  assumes the related clocks (a, b, d) are much slower than mclk.
  the related clocks arrive asynchronously and are re-timed in spd_rel_edge,
  so pulse edges lag the related edges by a fixed three to four mclk cycles.
  software keeps the ratio legal; nothing here clamps an oversize ratio.
*/
`timescale 1ns/1ps
module spd_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [2:0] rel_clk,
  output logic clk_out
);
  typedef struct packed {
    logic [23:0] cfg;
    logic [7:0] rdata;
    logic [23:0] cnt;
    logic [15:0] gap;
    spd_pkg::spd_state_type st;
    logic out;
  } spd_core_type;
  spd_core_type st_r, st_nxt;
  spd_pkg::spd_bus_type bus;
  logic rel_rise;
  logic frame;
  logic raw;

  // half-period length for the divider, rounded so odd ratios stay near 50%
  function automatic logic [23:0] half_len(input logic [23:0] r, input logic high);
    half_len = high ? (r >> 1) + {23'h0, r[0]} : (r >> 1);
  endfunction

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  spd_rel_edge u_edge (
    .mclk(mclk),
    .arst_n(arst_n),
    .rel_clk(rel_clk),
    .sel(st_r.cfg[spd_pkg::sel_msb:spd_pkg::sel_lsb]),
    .rise(rel_rise)
  );

  always_comb
  begin
    st_nxt = st_r;
    frame = (st_r.cfg[spd_pkg::mode_msb:spd_pkg::mode_lsb] == spd_pkg::frame_mode_code); // R1
    raw = 1'b0;
    // register port: three byte lanes, unmapped reads return zero
    st_nxt.rdata = 8'h00;
    // each byte lane lands at once; no shadow, so a ratio change spans writes
    if (bus.wr)
    begin
      if (bus.addr == spd_pkg::cfg_off_lo)
        st_nxt.cfg[7:0] = bus.wdata;
      if (bus.addr == spd_pkg::cfg_off_mid)
        st_nxt.cfg[15:8] = bus.wdata;
      if (bus.addr == spd_pkg::cfg_off_hi)
        st_nxt.cfg[23:16] = bus.wdata;
    end
    // read data is registered so rdata comes straight from a flop
    if (bus.rd)
    begin
      if (bus.addr == spd_pkg::cfg_off_lo)
        st_nxt.rdata = st_r.cfg[7:0];
      else if (bus.addr == spd_pkg::cfg_off_mid)
        st_nxt.rdata = st_r.cfg[15:8];
      else if (bus.addr == spd_pkg::cfg_off_hi)
        st_nxt.rdata = st_r.cfg[23:16];
    end
    if (!frame)
    begin
      // normal divider; ratio 0 or 1 parks the output low
      st_nxt.st = spd_pkg::spd_st_div;
      st_nxt.gap = 16'h0000;
      if (st_r.cfg < 24'h000002)
      begin
        st_nxt.out = 1'b0;
        st_nxt.cnt = 24'h000000;
      end
      else if (st_r.cnt + 24'h000001 >= half_len(st_r.cfg, st_r.out)) // R2
      begin
        st_nxt.cnt = 24'h000000;
        st_nxt.out = ~st_r.out;
      end
      else
        st_nxt.cnt = st_r.cnt + 24'h000001;
    end
    else
    begin
      // frame pulse: count related periods between pulses, pulse lasts one period
      st_nxt.cnt = 24'h000000;
      case (st_r.st)
        spd_pkg::spd_st_div:
        begin
          st_nxt.st = spd_pkg::spd_st_wait;
          st_nxt.gap = 16'h0000;
        end
        spd_pkg::spd_st_wait:
          if (rel_rise) // R9
          begin
            if (st_r.gap + 16'h0001 >= st_r.cfg[spd_pkg::period_msb:0]) // R4
            begin
              st_nxt.gap = 16'h0000;
              st_nxt.st = spd_pkg::spd_st_pulse;
            end
            else
              st_nxt.gap = st_r.gap + 16'h0001;
          end
        // the pulse-ending edge already counts as the first spacing period
        spd_pkg::spd_st_pulse:
          if (rel_rise) // R5 R9
          begin
            st_nxt.st = spd_pkg::spd_st_wait;
            st_nxt.gap = 16'h0001;
          end
        default:
          st_nxt.st = spd_pkg::spd_st_wait;
      endcase
      // type bit 19 is unused: the pulse always starts and ends on related rising edges
      raw = (st_nxt.st == spd_pkg::spd_st_pulse); // R8
      st_nxt.out = raw ^ st_r.cfg[spd_pkg::polar_bit]; // R7
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
      st_r.cfg <= spd_pkg::cfg_reset;
    end
    else
      st_r <= st_nxt;
  end

  assign rdata = st_r.rdata;
  assign clk_out = st_r.out;

  frame_polar_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (frame && st_r.st == spd_pkg::spd_st_wait && !rel_rise)
      |=> clk_out == $past(st_r.cfg[spd_pkg::polar_bit])) // R7
    else $error("idle frame pulse level wrong");
  // leaving the entry state is not tied to a related edge
  pulse_align_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (frame && $past(frame) && $changed(st_r.st) && st_r.st != spd_pkg::spd_st_div
      && $past(st_r.st) != spd_pkg::spd_st_div) |-> $past(rel_rise)) // R9
    else $error("pulse edge not on related edge");
  div_half_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frame && st_r.cfg == 24'h000004 && $past(st_r.cfg) == 24'h000004 && $rose(clk_out) && !bus.wr)
      |-> clk_out [*2] ##1 !clk_out) // R2
    else $error("divide by four not 50 percent");
  frame_mode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!frame) |=> st_r.st == spd_pkg::spd_st_div || frame) // R1
    else $error("frame state outside frame mode");
  read_back_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (rd && addr == spd_pkg::cfg_off_hi && !wr) |=> rdata == $past(st_r.cfg[23:16])) // R1
    else $error("config readback wrong");
  // low and middle lanes read back as well
  read_lo_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    (rd && addr == spd_pkg::cfg_off_lo && !wr) |=> rdata == $past(st_r.cfg[7:0]))
    else $error("low byte readback wrong");
  read_mid_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    (rd && addr == spd_pkg::cfg_off_mid && !wr) |=> rdata == $past(st_r.cfg[15:8]))
    else $error("middle byte readback wrong");
  // unmapped reads and idle cycles give zero
  read_unmapped_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    (rd && addr != spd_pkg::cfg_off_lo && addr != spd_pkg::cfg_off_mid && addr != spd_pkg::cfg_off_hi)
      |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  read_idle_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    (!rd) |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  // every write lands in its own byte lane on the next edge
  write_lo_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    (wr && addr == spd_pkg::cfg_off_lo) |=> st_r.cfg[7:0] == $past(wdata))
    else $error("low byte write lost");
  write_mid_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    (wr && addr == spd_pkg::cfg_off_mid) |=> st_r.cfg[15:8] == $past(wdata))
    else $error("middle byte write lost");
  write_hi_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
    (wr && addr == spd_pkg::cfg_off_hi) |=> st_r.cfg[23:16] == $past(wdata))
    else $error("high byte write lost");
  // ratio 0 or 1 parks the output low
  ratio_park_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    (!frame && st_r.cfg < 24'h000002) |=> !clk_out)
    else $error("small ratio output not parked");
  // the divider output only moves at the end of a half period
  div_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    (!frame && st_r.cfg >= 24'h000002 && st_r.cnt + 24'h000001 < half_len(st_r.cfg, st_r.out))
      |=> $stable(clk_out))
    else $error("divider output moved mid half period");
  // divider counter is idle in frame mode, spacing counter idle otherwise
  frame_cnt_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
    (frame) |=> st_r.cnt == 24'h000000)
    else $error("divider counter runs in frame mode");
  div_gap_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
    (!frame) |=> st_r.gap == 16'h0000)
    else $error("spacing counter runs in divider mode");
  // entering frame mode always starts a spacing count
  frame_entry_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
    (frame && st_r.st == spd_pkg::spd_st_div) |=> st_r.st == spd_pkg::spd_st_wait)
    else $error("frame entry skipped the wait state");
  // a related edge short of the count keeps waiting
  gap_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
    (frame && st_r.st == spd_pkg::spd_st_wait && rel_rise
      && st_r.gap + 16'h0001 < st_r.cfg[spd_pkg::period_msb:0]) |=> st_r.st == spd_pkg::spd_st_wait)
    else $error("pulse started before spacing count");
  // the pulse lasts until the next related edge and holds its active level
  pulse_end_a: assert property (@(posedge mclk) disable iff (!arst_n) // R9
    (frame && st_r.st == spd_pkg::spd_st_pulse && rel_rise) |=> st_r.st == spd_pkg::spd_st_wait)
    else $error("pulse outlived its related period");
  pulse_level_a: assert property (@(posedge mclk) disable iff (!arst_n) // R7
    (frame && st_r.st == spd_pkg::spd_st_pulse && !rel_rise)
      |=> clk_out == ~$past(st_r.cfg[spd_pkg::polar_bit]))
    else $error("active frame pulse level wrong");
endmodule

// *** testbench/spd_rel_model.sv ***
/* sibling divider clocks a, b and d for the frame pulse tests.
   assumes a 1 ns unit; periods 200, 300 and 400 ns. */
`timescale 1ns/1ps
module spd_rel_model (
  output logic [2:0] rel_clk
);
  // free running like real dividers; edges land on mclk falling edges, off the rising ones
  initial rel_clk = 3'h0;
  always #100 rel_clk[0] = ~rel_clk[0];
  always #150 rel_clk[1] = ~rel_clk[1];
  always #200 rel_clk[2] = ~rel_clk[2];
endmodule

// *** testbench/spd_top_tb.sv ***
/* self-checking bench for spd_top: registers, divider, frame pulse.
   assumes spd_rel_model drives the related clocks. */
`timescale 1ns/1ps
module spd_top_tb;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [2:0] rel_clk;
  logic clk_out;
  int miscompares = 0;
  int tests_run = 0;
  spd_top spd_top_inst (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rel_clk(rel_clk), .clk_out(clk_out));
  spd_rel_model spd_rel_model_inst (.rel_clk(rel_clk));
  initial forever #5 mclk = ~mclk;
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cmp(string n, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (e !== s)
    begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // one strobe cycle, then an idle edge so wr is never set twice at once
  task wr_b(logic [7:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task rd_b(logic [7:0] a, logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    cmp("rdata", {8'h00, e}, {8'h00, rdata});
    @(posedge mclk);
  endtask
  // length in mclk cycles of one whole run of clk_out at lvl
  task run(logic lvl, output logic [15:0] n);
    int i;
    int bad;
    n = 16'h0000;
    bad = 0;
    for (i = 0; i < 900 && clk_out !== lvl; i++) @(negedge mclk);
    if (i >= 900)
      bad++;
    for (i = 0; i < 900 && clk_out === lvl; i++) @(negedge mclk);
    if (i >= 900)
      bad++;
    for (i = 0; i < 900 && clk_out !== lvl; i++) @(negedge mclk);
    if (i >= 900)
      bad++;
    while (clk_out === lvl && n < 16'h0384)
    begin
      @(negedge mclk);
      n++;
    end
    if (bad > 0 || n >= 16'h0384)
    begin
      miscompares++;
      stop_test();
    end
    @(posedge mclk);
  endtask
  task t_regs;
    rd_b(spd_pkg::cfg_off_lo, 8'h00);
    rd_b(spd_pkg::cfg_off_hi, 8'h00);
    wr_b(spd_pkg::cfg_off_mid, 8'h5a);
    rd_b(spd_pkg::cfg_off_mid, 8'h5a);
    rd_b(8'ha1, 8'h00);
  endtask
  task t_div;
    logic [15:0] n;
    wr_b(spd_pkg::cfg_off_mid, 8'h00);
    for (int r = 4; r < 8; r++)
    begin
      wr_b(spd_pkg::cfg_off_lo, 8'(r));
      run(1'b1, n);
      cmp("div high", 16'((r + 1) / 2), n);
      run(1'b0, n);
      cmp("div low", 16'(r / 2), n);
    end
  endtask
  task t_frame;
    logic [1:0] sel [3] = '{spd_pkg::sel_a, spd_pkg::sel_b, spd_pkg::sel_d};
    logic [15:0] per [3] = '{16'h0014, 16'h001e, 16'h0028};
    logic [15:0] n;
    wr_b(spd_pkg::cfg_off_lo, 8'h02);
    for (int k = 0; k < 3; k++)
    begin
      wr_b(spd_pkg::cfg_off_hi, {spd_pkg::frame_mode_code, 1'(k > 0), 1'(k == 1), sel[k]});
      run(k != 1, n);
      cmp("pulse width", per[k], n);
      run(k == 1, n);
      // spacing 2 is pulse start to pulse start, so one inactive period
      cmp("pulse gap", per[k], n);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_div();
    t_frame();
    stop_test();
  end
endmodule
